/* dv/pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output var  logic pin_level
);
    // pad carries a pull-up, so a released pin reads high
    always_comb pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule : pin_partner
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_wave_map.svh"
module testbench;
    import timer_wave_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, timer_tick;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pin_out, pin_oe_n, pin_level, err;
    int          n_errors, n_checks, seed, k;
    int          cnt, act_cmp, buf_cmp, mode, act, latch, ovf, cmpf, blk, pdata, pdir;
    timer_wave i_timer_wave (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .timer_tick(timer_tick),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n));
    pin_partner i_pin_partner (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));
    always #2.5 pclk = ~pclk;
    // ************************************************************
    // bus tasks and reference model
    // ************************************************************
    task automatic tally_and_finish();
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_errors++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic apply(input int a);
        if (a == 1) latch = 1 - latch;
        if (a == 2) latch = 0;
        if (a == 3) latch = 1;
    endtask : apply
    task automatic reg_wr(input logic [7:0] a, input int d);
        apb(1'b1, a, 32'(d));
        case (a)
            `TW_CTRL_OFS: begin
                mode = d % 4;
                act = (d / 4) % 4;
                if ((d & 128) != 0 && (mode == 0 || mode == 2)) apply(act);
            end
            `TW_COUNT_OFS: begin
                cnt = d % 256;
                blk = 1;
            end
            `TW_CMP_OFS: begin
                buf_cmp = d % 256;
                if (mode == 0 || mode == 2) act_cmp = buf_cmp;
            end
            `TW_STAT_OFS: begin
                if (d % 2 == 1) ovf = 0;
                if ((d / 2) % 2 == 1) cmpf = 0;
            end
            `TW_PORT_OFS: begin
                pdata = d % 2;
                pdir = (d / 2) % 2;
            end
            default: ;
        endcase
    endtask : reg_wr
    task automatic step();
        int m;
        m = (cnt == act_cmp && blk == 0) ? 1 : 0;
        blk = 0;
        if (m == 1) cmpf = 1;
        if (cnt == 255 && !(m == 1 && mode == 2)) ovf = 1;
        if (m == 1) apply(act);
        else if (mode == 3 && cnt == 255 && act >= 2) apply(5 - act);
        if (mode == 3 && cnt == 255) act_cmp = buf_cmp;
        cnt = (m == 1 && mode == 2) ? 0 : (cnt + 1) % 256;
    endtask : step
    task automatic run_ticks(input int n);
        int t;
        while (n > 0) begin
            t = $urandom % 2;
            @(posedge pclk);
            timer_tick <= t[0];
            if (t == 1) begin
                step();
                n--;
            end
        end
        @(posedge pclk);
        timer_tick <= 1'b0;
    endtask : run_ticks
    task automatic verify();
        apb(1'b0, `TW_CTRL_OFS, 32'h0);
        check("ctrl", 32'(act * 4 + mode), rd);
        apb(1'b0, `TW_COUNT_OFS, 32'h0);
        check("count", 32'(cnt), rd);
        apb(1'b0, `TW_CMP_OFS, 32'h0);
        check("compare", 32'(buf_cmp), rd);
        apb(1'b0, `TW_STAT_OFS, 32'h0);
        check("status", 32'(latch * 4 + cmpf * 2 + ovf), rd);
        check("slverr", 32'h0, 32'(err));
        apb(1'b0, `TW_PORT_OFS, 32'h0);
        check("port", 32'(pdir * 2 + pdata), rd);
        check("pin", 32'(pdir == 0 ? 1 : (act != 0 ? latch : pdata)), 32'(pin_level));
        check("pin_oe_n", 32'(1 - pdir), 32'(pin_oe_n));
        reg_wr(`TW_STAT_OFS, 3);
    endtask : verify
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        timer_tick = 1'b0;
        {n_errors, n_checks, cnt, act_cmp, buf_cmp, mode, act} = '0;
        {latch, ovf, cmpf, blk, pdata, pdir} = '0;
        seed = $urandom(74);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        verify();
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped read", 32'h0, rd);
        check("unmapped slverr", 32'h1, 32'(err));
        apb(1'b1, 8'h14, 32'hFFFFFFFF);
        reg_wr(`TW_CTRL_OFS, 8'h8C);
        reg_wr(`TW_PORT_OFS, 2);
        verify();
        for (k = 0; k < 36; k++) begin
            reg_wr(`TW_CTRL_OFS, 128 * ($urandom % 2) + 4 * ((k / 3) % 4) + (k % 3 == 0 ? 0 : k % 3 + 1));
            reg_wr(`TW_CMP_OFS, (k % 9 == 7) ? 255 : ((k % 9 == 8) ? 0 : $urandom % 256));
            reg_wr(`TW_COUNT_OFS, ($urandom % 2 == 1) ? act_cmp : $urandom % 256);
            reg_wr(`TW_PORT_OFS, $urandom % 4);
            run_ticks((k % 4 == 0) ? 1 : 1 + $urandom % 600);
            verify();
        end
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire

/* logic/timer_wave.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_wave_map.svh"
module timer_wave (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        timer_tick,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  logic        pin_out,
    output var  logic        pin_oe_n
);
    import timer_wave_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic is_pwm(input wave_mode_t m);
        is_pwm = (m == MODE_PHASE) || (m == MODE_FAST);
    endfunction : is_pwm

    function automatic logic apply_act(input out_action_t a, input logic oc);
        case (a)
            ACT_TOGGLE: apply_act = ~oc;
            ACT_CLEAR:  apply_act = 1'b0;
            ACT_SET:    apply_act = 1'b1;
            default:    apply_act = oc;
        endcase
    endfunction : apply_act

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == `TW_CTRL_OFS) || (a == `TW_COUNT_OFS) ||
                  (a == `TW_CMP_OFS) || (a == `TW_STAT_OFS) ||
                  (a == `TW_PORT_OFS);
    endfunction : addr_ok

    // ****************************************
    // state
    // ****************************************
    ctrl_t       ctrl_r;
    flags_t      flags_r;
    logic [7:0]  counter_value_r;
    logic [7:0]  compare_value_r;
    logic [7:0]  compare_buf_r;
    logic        block_r;
    logic        compare_output_r;
    logic        port_data_r;
    logic        output_pin_direction_bit_r;
    logic        pready_r;

    wave_mode_t  mode;
    out_action_t act;
    logic        acc;
    logic        wr;
    logic        wr_ctrl;
    logic        wr_cnt;
    logic        wr_cmp;
    logic        wr_stat;
    logic        wr_port;
    logic        hit;
    logic        at_max;
    logic        force_ev;
    ctrl_t       wctrl;

    assign mode     = ctrl_r.waveform_mode_field;
    assign act      = ctrl_r.output_action_field;
    assign acc      = psel & penable & pready_r;
    assign wr       = acc & pwrite;
    assign wr_ctrl  = wr & (paddr == `TW_CTRL_OFS);
    assign wr_cnt   = wr & (paddr == `TW_COUNT_OFS);
    assign wr_cmp   = wr & (paddr == `TW_CMP_OFS);
    assign wr_stat  = wr & (paddr == `TW_STAT_OFS);
    assign wr_port  = wr & (paddr == `TW_PORT_OFS);
    assign wctrl    = ctrl_t'(pwdata[3:0]);
    assign at_max   = (counter_value_r == `TW_MAX);
    assign hit      = (counter_value_r == compare_value_r) & ~block_r;
    assign force_ev = wr_ctrl & pwdata[`TW_FORCE_BIT] &
                      ~is_pwm(wctrl.waveform_mode_field);

    // ****************************************
    // apb slave
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= psel & penable & ~pready_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready_r) begin
            pslverr <= ~addr_ok(paddr);
            prdata  <= 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    `TW_CTRL_OFS:  prdata[3:0] <= ctrl_r;
                    `TW_COUNT_OFS: prdata[7:0] <= counter_value_r;
                    `TW_CMP_OFS:   prdata[7:0] <= compare_buf_r;
                    `TW_STAT_OFS: begin
                        prdata[`TW_OVF_BIT]  <= flags_r.overflow_flag;
                        prdata[`TW_CMPF_BIT] <= flags_r.compare_flag;
                        prdata[`TW_OC_BIT]   <= compare_output_r;
                    end
                    `TW_PORT_OFS: begin
                        prdata[`TW_PDATA_BIT] <= port_data_r;
                        prdata[`TW_PDIR_BIT]  <= output_pin_direction_bit_r;
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end else begin
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready_r;
        end
    end

    // ****************************************
    // control and port registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= ctrl_t'(`TW_CTRL_RST);
        end else if (wr_ctrl) begin
            ctrl_r <= wctrl;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_data_r                <= 1'b0;
            output_pin_direction_bit_r <= 1'b0;
        end else if (wr_port) begin
            port_data_r                <= pwdata[`TW_PDATA_BIT];
            output_pin_direction_bit_r <= pwdata[`TW_PDIR_BIT];
        end
    end

    // ****************************************
    // counter
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_r <= 1'b0;
        end else if (wr_cnt) begin
            block_r <= 1'b1;
        end else if (timer_tick) begin
            block_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value_r <= `TW_COUNT_RST;
        end else if (wr_cnt) begin
            counter_value_r <= pwdata[7:0];
        end else if (timer_tick) begin
            if ((mode == MODE_CLEAR) && hit) begin
                counter_value_r <= `TW_BOTTOM;
            end else begin
                counter_value_r <= counter_value_r + 8'h01;
            end
        end
    end

    // ****************************************
    // compare value and buffer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_buf_r <= `TW_CMP_RST;
        end else if (wr_cmp) begin
            compare_buf_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value_r <= `TW_CMP_RST;
        end else if (wr_cmp && !is_pwm(mode)) begin
            compare_value_r <= pwdata[7:0];
        end else if (timer_tick && is_pwm(mode) && at_max) begin
            compare_value_r <= compare_buf_r;
        end
    end

    // ****************************************
    // flags, set wins over clear
    // ****************************************
    logic set_ovf;
    logic set_cmp;
    assign set_ovf = timer_tick & ~wr_cnt & at_max &
                     ~((mode == MODE_CLEAR) & hit);
    assign set_cmp = timer_tick & hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= '0;
        end else begin
            flags_r.overflow_flag <= (flags_r.overflow_flag &
                ~(wr_stat & pwdata[`TW_OVF_BIT])) | set_ovf;
            flags_r.compare_flag  <= (flags_r.compare_flag &
                ~(wr_stat & pwdata[`TW_CMPF_BIT])) | set_cmp;
        end
    end

    // ****************************************
    // waveform generator
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_output_r <= 1'b0;
        end else if (force_ev) begin
            compare_output_r <= apply_act(wctrl.output_action_field,
                                          compare_output_r);
        end else if (timer_tick && (act != ACT_OFF)) begin
            case (mode)
                MODE_NORMAL, MODE_CLEAR: begin
                    if (hit) begin
                        compare_output_r <= apply_act(act, compare_output_r);
                    end
                end
                MODE_FAST: begin
                    if (hit) begin
                        compare_output_r <= apply_act(act, compare_output_r);
                    end else if (at_max && (act == ACT_CLEAR)) begin
                        compare_output_r <= 1'b1;
                    end else if (at_max && (act == ACT_SET)) begin
                        compare_output_r <= 1'b0;
                    end
                end
                default: compare_output_r <= compare_output_r;
            endcase
        end
    end

    // ****************************************
    // pin override
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out  <= 1'b0;
            pin_oe_n <= 1'b1;
        end else begin
            pin_out  <= (act != ACT_OFF) ? compare_output_r : port_data_r;
            pin_oe_n <= ~output_pin_direction_bit_r;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_wrap;
        timer_tick && at_max && !wr_cnt;
    endsequence

    sequence s_fast_bottom;
        s_wrap and (mode == MODE_FAST && !hit);
    endsequence

    property p_block;
        @(posedge pclk) disable iff (!presetn) wr_cnt |=> !hit;
    endproperty
    a_block: assert property (p_block) else $error("match not blocked");

    property p_mode_keep;
        @(posedge pclk) disable iff (!presetn)
            wr_ctrl && !force_ev && !timer_tick |=> $stable(compare_output_r);
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("latch moved");

    property p_pin;
        @(posedge pclk) disable iff (!presetn)
            act != ACT_OFF |=> pin_out == $past(compare_output_r);
    endproperty
    a_pin: assert property (p_pin) else $error("pin not overridden");

    property p_no_act;
        @(posedge pclk) disable iff (!presetn)
            act == ACT_OFF && !wr_ctrl |=> $stable(compare_output_r);
    endproperty
    a_no_act: assert property (p_no_act) else $error("latch moved");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
            s_wrap and (mode == MODE_NORMAL) |=>
            counter_value_r == `TW_BOTTOM && flags_r.overflow_flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("bad wrap");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
            timer_tick && hit && !wr_cnt && mode == MODE_CLEAR
            |=> counter_value_r == `TW_BOTTOM;
    endproperty
    a_clear: assert property (p_clear) else $error("no clear");

    property p_toggle;
        @(posedge pclk) disable iff (!presetn)
            timer_tick && hit && act == ACT_TOGGLE && !wr_ctrl && mode != MODE_PHASE
            |=> compare_output_r != $past(compare_output_r);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");

    property p_bottom;
        @(posedge pclk) disable iff (!presetn)
            s_fast_bottom and (act == ACT_CLEAR && !wr_ctrl) |=> compare_output_r;
    endproperty
    a_bottom: assert property (p_bottom) else $error("not set at bottom");

    property p_cmpf;
        @(posedge pclk) disable iff (!presetn)
            set_cmp |=> flags_r.compare_flag;
    endproperty
    a_cmpf: assert property (p_cmpf) else $error("flag not set");

    property p_buf;
        @(posedge pclk) disable iff (!presetn)
            is_pwm(mode) && !at_max |=> $stable(compare_value_r);
    endproperty
    a_buf: assert property (p_buf) else $error("unbuffered update");

    property p_idle;
        @(posedge pclk) disable iff (!presetn)
            !timer_tick && !wr_cnt |=> $stable(counter_value_r);
    endproperty
    a_idle: assert property (p_idle) else $error("count moved");

    property p_force_keep;
        @(posedge pclk) disable iff (!presetn)
            force_ev && !timer_tick |=> $stable(counter_value_r) && !$rose(flags_r.compare_flag);
    endproperty
    a_force_keep: assert property (p_force_keep) else $error("force moved count");

    property p_direct;
        @(posedge pclk) disable iff (!presetn)
            wr_cmp && !is_pwm(mode) |=> compare_value_r == $past(pwdata[7:0]);
    endproperty
    a_direct: assert property (p_direct) else $error("compare not direct");

    property p_reload;
        @(posedge pclk) disable iff (!presetn)
            timer_tick && is_pwm(mode) && at_max |=> compare_value_r == $past(compare_buf_r);
    endproperty
    a_reload: assert property (p_reload) else $error("buffer not loaded");

    property p_fast_top;
        @(posedge pclk) disable iff (!presetn)
            s_wrap and (mode == MODE_FAST) |=>
            counter_value_r == `TW_BOTTOM && flags_r.overflow_flag;
    endproperty
    a_fast_top: assert property (p_fast_top) else $error("bad fast wrap");

    property p_clear_ovf;
        @(posedge pclk) disable iff (!presetn)
            s_wrap and (mode == MODE_CLEAR && !hit) |=> flags_r.overflow_flag;
    endproperty
    a_clear_ovf: assert property (p_clear_ovf) else $error("no overflow");

    property p_oe;
        @(posedge pclk) disable iff (!presetn)
            output_pin_direction_bit_r |=> !pin_oe_n;
    endproperty
    a_oe: assert property (p_oe) else $error("pin not driven");
endmodule : timer_wave
`default_nettype wire

/* logic/timer_wave_map.svh */
`ifndef TIMER_WAVE_MAP_SVH
`define TIMER_WAVE_MAP_SVH
`define TW_CTRL_OFS     8'h00
`define TW_COUNT_OFS    8'h04
`define TW_CMP_OFS      8'h08
`define TW_STAT_OFS     8'h0C
`define TW_PORT_OFS     8'h10
`define TW_MODE_LSB     0
`define TW_ACT_LSB      2
`define TW_FORCE_BIT    7
`define TW_OVF_BIT      0
`define TW_CMPF_BIT     1
`define TW_OC_BIT       2
`define TW_PDATA_BIT    0
`define TW_PDIR_BIT     1
`define TW_CTRL_RST     4'h0
`define TW_COUNT_RST    8'h00
`define TW_CMP_RST      8'h00
`define TW_MAX          8'hFF
`define TW_BOTTOM       8'h00
`endif

/* logic/timer_wave_pkg.sv */
`default_nettype none
package timer_wave_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_PHASE  = 2'h1,
        MODE_CLEAR  = 2'h2,
        MODE_FAST   = 2'h3
    } wave_mode_t;
    typedef enum logic [1:0] {
        ACT_OFF    = 2'h0,
        ACT_TOGGLE = 2'h1,
        ACT_CLEAR  = 2'h2,
        ACT_SET    = 2'h3
    } out_action_t;
    typedef struct packed {
        out_action_t output_action_field;
        wave_mode_t  waveform_mode_field;
    } ctrl_t;
    typedef struct packed {
        logic compare_flag;
        logic overflow_flag;
    } flags_t;
endpackage : timer_wave_pkg
`default_nettype wire
